// ### rtl/drive_ramp_pkg.sv
package drive_ramp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RAMP_TICK_NS  = 1000000;
  localparam int unsigned TICK_CYCLES   = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_S   = 1000000000 / RAMP_TICK_NS;
  localparam logic [7:0] MODE_VL   = 8'h02;
  localparam logic [7:0] MODE_PV   = 8'h03;
  localparam logic [7:0] PROF_TRAP = 8'h00;
  localparam logic [7:0] PROF_JERK = 8'h03;
  localparam logic [7:0] REV_ELEC  = 8'h00;
  localparam int HALT_BIT    = 8;
  localparam int QSTOP_BIT   = 2;
  localparam int REACHED_BIT = 10;
  localparam int LIMIT_BIT   = 11;
  localparam int POL_VEL_BIT = 6;
  localparam logic [15:0] CTRL_RST = 16'h0104;
  localparam logic [31:0] ONE      = 32'h0000_0001;
  localparam logic [31:0] VMAX_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] SEC_PER_MIN = 32'h0000_003C;
  localparam logic [7:0] A_MODE   = 8'h00;
  localparam logic [7:0] A_CTRL   = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_VLTGT  = 8'h0C;
  localparam logic [7:0] A_ACCDS  = 8'h10;
  localparam logic [7:0] A_ACCDT  = 8'h14;
  localparam logic [7:0] A_DECDS  = 8'h18;
  localparam logic [7:0] A_DECDT  = 8'h1C;
  localparam logic [7:0] A_QSDS   = 8'h20;
  localparam logic [7:0] A_QSDT   = 8'h24;
  localparam logic [7:0] A_VMIN   = 8'h28;
  localparam logic [7:0] A_VMAX   = 8'h2C;
  localparam logic [7:0] A_DIMNUM = 8'h30;
  localparam logic [7:0] A_DIMDEN = 8'h34;
  localparam logic [7:0] A_REVTYP = 8'h38;
  localparam logic [7:0] A_PVTGT  = 8'h3C;
  localparam logic [7:0] A_PVACC  = 8'h40;
  localparam logic [7:0] A_PVDEC  = 8'h44;
  localparam logic [7:0] A_PVQS   = 8'h48;
  localparam logic [7:0] A_PROF   = 8'h4C;
  localparam logic [7:0] A_POL    = 8'h50;
  localparam logic [7:0] A_WIN    = 8'h54;
  localparam logic [7:0] A_WINT   = 8'h58;
  localparam logic [7:0] A_DEMAND = 8'h5C;
  localparam logic [7:0] A_ACTUAL = 8'h60;
  localparam logic [7:0] A_JERK   = 8'h64;
endpackage : drive_ramp_pkg

// ### rtl/drive_velocity_ramp.sv
`timescale 1ns/1ps
module drive_velocity_ramp #(
  parameter int unsigned TICK_CYCLES = drive_ramp_pkg::TICK_CYCLES,
  parameter logic [31:0] POLE_PAIRS  = 32'h0000_0001
) (
  // Clock, reset and enable.
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  input  wire logic               enable_in,
  // Avalon-MM register slave.
  input  wire logic [7:0]         address_in,
  input  wire logic               read_in,
  input  wire logic               write_in,
  input  wire logic [31:0]        writedata_in,
  output logic [31:0]             readdata_out,
  output logic                    waitrequest_out,
  // Drive side.
  input  wire logic               op_enabled_in,
  input  wire logic signed [31:0] actual_rpm_in,
  output logic signed [31:0]      setpoint_out,
  output logic [15:0]             status_out
);
  typedef struct packed {
    logic [7:0]         mode;
    logic [15:0]        ctrl;
    logic signed [31:0] vl_tgt;
    logic signed [31:0] pv_tgt;
    logic [31:0]        acc_ds;
    logic [31:0]        acc_dt;
    logic [31:0]        dec_ds;
    logic [31:0]        dec_dt;
    logic [31:0]        qs_ds;
    logic [31:0]        qs_dt;
    logic [31:0]        vmin;
    logic [31:0]        vmax;
    logic [31:0]        dim_num;
    logic [31:0]        dim_den;
    logic [7:0]         rev_type;
    logic [31:0]        pv_acc;
    logic [31:0]        pv_dec;
    logic [31:0]        pv_qs;
    logic [7:0]         prof;
    logic [7:0]         pol;
    logic [31:0]        win;
    logic [31:0]        win_time;
    logic [31:0]        jerk;
    logic signed [31:0] demand;
    logic signed [31:0] actual;
    logic [31:0]        acc_now;
    logic [31:0]        tick_cnt;
    logic [31:0]        dwell;
    logic               reached;
    logic               limit;
    logic               waitreq;
    logic [31:0]        rdata;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [31:0] mag_of(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag_of

  function automatic logic [31:0] per_tick(input logic [31:0] rate, input logic [31:0] secs);
    logic [31:0] den;
    logic [31:0] q;
    den = 32'(secs * drive_ramp_pkg::TICKS_PER_S);
    q = (den == 32'h0) ? rate : rate / den;
    return (q == 32'h0) ? drive_ramp_pkg::ONE : q;
  endfunction : per_tick

  ////////////////////////////////////////////////////////////////////////////
  logic               is_vl;
  logic               is_pv;
  logic               halt;
  logic               tick;
  logic signed [31:0] raw_tgt;
  logic signed [31:0] pol_tgt;
  logic [31:0]        tgt_mag;
  logic [31:0]        lim_mag;
  logic               over_max;
  logic               under_min;
  logic signed [31:0] goal;
  logic [31:0]        goal_mag;
  logic [31:0]        dem_mag;
  logic               speed_up;
  logic [31:0]        step_lim;
  logic [31:0]        step;
  logic [31:0]        jerk_step;
  logic signed [31:0] diff;
  logic signed [31:0] dev;
  logic               in_win;
  logic [63:0]        act_scaled;
  logic               req;
  logic               accept;

  always_comb
  begin
    next_st = st;
    is_vl = st.mode == drive_ramp_pkg::MODE_VL;
    is_pv = st.mode == drive_ramp_pkg::MODE_PV;
    halt = st.ctrl[drive_ramp_pkg::HALT_BIT];
    tick = st.tick_cnt == 32'(TICK_CYCLES - 1);
    next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + drive_ramp_pkg::ONE;

    raw_tgt = is_pv ? st.pv_tgt : st.vl_tgt;
    pol_tgt = st.pol[drive_ramp_pkg::POL_VEL_BIT] ? 32'(-raw_tgt) : raw_tgt;
    tgt_mag = mag_of(pol_tgt);
    over_max = tgt_mag > st.vmax;
    under_min = is_vl && tgt_mag < st.vmin;
    lim_mag = over_max ? st.vmax : (under_min ? st.vmin : tgt_mag);
    goal = pol_tgt[31] ? 32'(-lim_mag) : 32'(lim_mag);
    // A halted, quick-stopped or unsupported-mode axis ramps to zero; a disabled one (op_enabled_in low) drops to zero at once.
    if (halt || !st.ctrl[drive_ramp_pkg::QSTOP_BIT] || !op_enabled_in
        || !(is_vl || is_pv))
      goal = 32'sh0;
    goal_mag = mag_of(goal);
    dem_mag = mag_of(st.demand);
    speed_up = goal_mag > dem_mag && (st.demand == 32'sh0 || goal[31] == st.demand[31]);

    // Ramp selection by mode, direction and quick stop.
    if (!st.ctrl[drive_ramp_pkg::QSTOP_BIT])
      step_lim = is_pv ? per_tick(st.pv_qs, drive_ramp_pkg::ONE)
                       : per_tick(st.qs_ds, st.qs_dt);
    else if (speed_up)
      step_lim = is_pv ? per_tick(st.pv_acc, drive_ramp_pkg::ONE)
                       : per_tick(st.acc_ds, st.acc_dt);
    else
      step_lim = is_pv ? per_tick(st.pv_dec, drive_ramp_pkg::ONE)
                       : per_tick(st.dec_ds, st.dec_dt);
    jerk_step = per_tick(per_tick(st.jerk, drive_ramp_pkg::ONE), drive_ramp_pkg::ONE);

    // Jerk limiting only grows the step; plain mode always takes the full step.
    if (is_pv && st.prof == drive_ramp_pkg::PROF_JERK)
      step = (st.acc_now + jerk_step > step_lim) ? step_lim : st.acc_now + jerk_step;
    else
      step = step_lim;

    diff = 32'(goal - st.demand);
    if (tick)
    begin
      if (mag_of(diff) <= step)
      begin
        next_st.demand = goal;
        next_st.acc_now = 32'h0;
      end
      else
      begin
        next_st.demand = diff[31] ? 32'(st.demand - $signed(step))
                                  : 32'(st.demand + $signed(step));
        next_st.acc_now = step;
      end
    end
    if (!op_enabled_in)
    begin
      next_st.demand = 32'sh0;
      next_st.acc_now = 32'h0;
    end
    next_st.limit = is_vl && (over_max || under_min);

    // Measured speed arrives as mechanical rpm from the speed loop.
    act_scaled = 64'($signed(actual_rpm_in));
    if (st.rev_type == drive_ramp_pkg::REV_ELEC)
      act_scaled = 64'($signed(act_scaled) * $signed({32'h0, POLE_PAIRS}));
    if (!(st.dim_num == drive_ramp_pkg::ONE && st.dim_den == drive_ramp_pkg::ONE)
        && st.dim_den != 32'h0)
      act_scaled = 64'($signed(act_scaled) * $signed({32'h0, st.dim_num})
                   / $signed({32'h0, 32'(st.dim_den * drive_ramp_pkg::SEC_PER_MIN)}));
    next_st.actual = act_scaled[31:0];

    dev = 32'(st.actual - st.demand);
    in_win = mag_of(dev) <= st.win;
    if (!in_win)
    begin
      next_st.dwell = 32'h0;
      next_st.reached = 1'b0;
    end
    else if (tick)
    begin
      if (st.dwell >= st.win_time)
        next_st.reached = 1'b1;
      else
        next_st.dwell = st.dwell + drive_ramp_pkg::ONE;
    end

    // Bus: drop waitrequest for one cycle; the access completes on that edge.
    req = read_in || write_in;
    accept = req && !st.waitreq;
    next_st.waitreq = !(req && st.waitreq);
    if (req && st.waitreq)
    begin
      unique case (address_in)
        drive_ramp_pkg::A_MODE:   next_st.rdata = {24'h0, st.mode};
        drive_ramp_pkg::A_CTRL:   next_st.rdata = {16'h0, st.ctrl};
        drive_ramp_pkg::A_STAT:   next_st.rdata = {16'h0, status_out};
        drive_ramp_pkg::A_VLTGT:  next_st.rdata = st.vl_tgt;
        drive_ramp_pkg::A_ACCDS:  next_st.rdata = st.acc_ds;
        drive_ramp_pkg::A_ACCDT:  next_st.rdata = st.acc_dt;
        drive_ramp_pkg::A_DECDS:  next_st.rdata = st.dec_ds;
        drive_ramp_pkg::A_DECDT:  next_st.rdata = st.dec_dt;
        drive_ramp_pkg::A_QSDS:   next_st.rdata = st.qs_ds;
        drive_ramp_pkg::A_QSDT:   next_st.rdata = st.qs_dt;
        drive_ramp_pkg::A_VMIN:   next_st.rdata = st.vmin;
        drive_ramp_pkg::A_VMAX:   next_st.rdata = st.vmax;
        drive_ramp_pkg::A_DIMNUM: next_st.rdata = st.dim_num;
        drive_ramp_pkg::A_DIMDEN: next_st.rdata = st.dim_den;
        drive_ramp_pkg::A_REVTYP: next_st.rdata = {24'h0, st.rev_type};
        drive_ramp_pkg::A_PVTGT:  next_st.rdata = st.pv_tgt;
        drive_ramp_pkg::A_PVACC:  next_st.rdata = st.pv_acc;
        drive_ramp_pkg::A_PVDEC:  next_st.rdata = st.pv_dec;
        drive_ramp_pkg::A_PVQS:   next_st.rdata = st.pv_qs;
        drive_ramp_pkg::A_PROF:   next_st.rdata = {24'h0, st.prof};
        drive_ramp_pkg::A_POL:    next_st.rdata = {24'h0, st.pol};
        drive_ramp_pkg::A_WIN:    next_st.rdata = st.win;
        drive_ramp_pkg::A_WINT:   next_st.rdata = st.win_time;
        drive_ramp_pkg::A_DEMAND: next_st.rdata = st.demand;
        drive_ramp_pkg::A_ACTUAL: next_st.rdata = st.actual;
        drive_ramp_pkg::A_JERK:   next_st.rdata = st.jerk;
        default:                  next_st.rdata = 32'h0;
      endcase
    end
    if (accept && write_in)
    begin
      unique case (address_in)
        drive_ramp_pkg::A_MODE:   next_st.mode = writedata_in[7:0];
        drive_ramp_pkg::A_CTRL:   next_st.ctrl = writedata_in[15:0];
        drive_ramp_pkg::A_VLTGT:  next_st.vl_tgt = writedata_in;
        drive_ramp_pkg::A_ACCDS:  next_st.acc_ds = writedata_in;
        drive_ramp_pkg::A_ACCDT:  next_st.acc_dt = writedata_in;
        drive_ramp_pkg::A_DECDS:  next_st.dec_ds = writedata_in;
        drive_ramp_pkg::A_DECDT:  next_st.dec_dt = writedata_in;
        drive_ramp_pkg::A_QSDS:   next_st.qs_ds = writedata_in;
        drive_ramp_pkg::A_QSDT:   next_st.qs_dt = writedata_in;
        drive_ramp_pkg::A_VMIN:   next_st.vmin = writedata_in;
        drive_ramp_pkg::A_VMAX:   next_st.vmax = writedata_in;
        drive_ramp_pkg::A_DIMNUM: next_st.dim_num = writedata_in;
        drive_ramp_pkg::A_DIMDEN: next_st.dim_den = writedata_in;
        drive_ramp_pkg::A_REVTYP: next_st.rev_type = writedata_in[7:0];
        drive_ramp_pkg::A_PVTGT:  next_st.pv_tgt = writedata_in;
        drive_ramp_pkg::A_PVACC:  next_st.pv_acc = writedata_in;
        drive_ramp_pkg::A_PVDEC:  next_st.pv_dec = writedata_in;
        drive_ramp_pkg::A_PVQS:   next_st.pv_qs = writedata_in;
        drive_ramp_pkg::A_PROF:   next_st.prof = writedata_in[7:0];
        drive_ramp_pkg::A_POL:    next_st.pol = writedata_in[7:0];
        drive_ramp_pkg::A_WIN:    next_st.win = writedata_in;
        drive_ramp_pkg::A_WINT:   next_st.win_time = writedata_in;
        drive_ramp_pkg::A_JERK:   next_st.jerk = writedata_in;
        default:                  next_st.mode = st.mode;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st <= '0;
      st.ctrl <= drive_ramp_pkg::CTRL_RST;
      st.vmax <= drive_ramp_pkg::VMAX_RST;
      st.dim_num <= drive_ramp_pkg::ONE;
      st.dim_den <= drive_ramp_pkg::ONE;
      st.acc_dt <= drive_ramp_pkg::ONE;
      st.dec_dt <= drive_ramp_pkg::ONE;
      st.qs_dt <= drive_ramp_pkg::ONE;
      st.waitreq <= 1'b1;
    end
    else if (enable_in)
      st <= next_st;
  end

  assign readdata_out    = st.rdata;
  assign waitrequest_out = st.waitreq;
  assign setpoint_out    = st.demand;
  assign status_out      = {4'h0, st.limit, st.reached, 10'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Checks; the demand moves only on ramp ticks or when op_enabled_in drops, so several are qualified by tick.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  chk_halt_holds_zero: assert property (
    enable_in && halt && st.demand == 32'sh0 |=> st.demand == 32'sh0)
    else $error("halted axis left standstill");
  chk_clamp_max: assert property (
    over_max && (halt == 1'b0) && op_enabled_in && (is_vl || is_pv)
    && st.ctrl[drive_ramp_pkg::QSTOP_BIT] |-> goal_mag == st.vmax)
    else $error("target above maximum not clamped");
  chk_clamp_min: assert property (
    under_min && !over_max && !halt && op_enabled_in
    && st.ctrl[drive_ramp_pkg::QSTOP_BIT] |-> goal_mag == st.vmin)
    else $error("target below minimum not clamped");
  chk_limit_bit: assert property (
    enable_in && is_vl && (over_max || under_min) |=> status_out[drive_ramp_pkg::LIMIT_BIT])
    else $error("limit bit missing while clamping");
  chk_reach_dwell: assert property (
    $rose(st.reached) |-> st.dwell >= st.win_time && $past(in_win))
    else $error("speed reached without full dwell");
  chk_leave_clears: assert property (
    enable_in && !in_win |=> !st.reached && st.dwell == 32'h0)
    else $error("leaving window did not clear reached");
  chk_polarity: assert property (
    st.pol[drive_ramp_pkg::POL_VEL_BIT] && is_pv && !halt && op_enabled_in && !over_max
    && st.ctrl[drive_ramp_pkg::QSTOP_BIT] && raw_tgt > 32'sh0 |-> goal == 32'(-raw_tgt))
    else $error("polarity inversion missing");
  chk_demand_tick: assert property (
    enable_in && !tick && op_enabled_in |=> $stable(setpoint_out))
    else $error("demand moved between ticks");
  chk_plain_nojerk: assert property (
    is_vl |-> step == step_lim)
    else $error("plain mode used a jerk-limited step");
  chk_bus_answer: assert property (
    enable_in && req && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
    else $error("bus answer not one cycle");
  chk_op_zero: assert property (
    enable_in && !op_enabled_in
    |=> setpoint_out == 32'sh0)
    else $error("disabled drive kept a demand");
  chk_idle_mode: assert property (
    enable_in && !(is_vl || is_pv) && setpoint_out == 32'sh0
    |=> setpoint_out == 32'sh0)
    else $error("unsupported mode moved the axis");
  chk_qstop_goal: assert property (
    !st.ctrl[drive_ramp_pkg::QSTOP_BIT]
    |-> goal == 32'sh0)
    else $error("quick stop did not aim at standstill");
  chk_halt_brakes: assert property (
    enable_in && halt && tick && st.demand != 32'sh0
    |=> mag_of(setpoint_out) < mag_of($past(setpoint_out)))
    else $error("halt did not brake the axis");
  chk_step_bound: assert property (
    enable_in && op_enabled_in && tick
    |=> mag_of(32'(setpoint_out - $past(setpoint_out))) <= $past(step))
    else $error("demand stepped past its ramp");
  chk_limit_clear: assert property (
    enable_in && !(is_vl && (over_max || under_min))
    |=> !status_out[drive_ramp_pkg::LIMIT_BIT])
    else $error("limit bit stuck without a clamp");
  chk_reach_tick: assert property (
    $rose(st.reached)
    |-> $past(tick))
    else $error("speed reached set off a tick");
  chk_dwell_count: assert property (
    enable_in && tick && in_win && st.dwell < st.win_time
    |=> st.dwell == $past(st.dwell) + drive_ramp_pkg::ONE)
    else $error("window dwell did not count");
  chk_trap_full: assert property (
    is_pv && st.prof == drive_ramp_pkg::PROF_TRAP
    |-> step == step_lim)
    else $error("trapezoidal ramp shortened its step");
  chk_mode_write: assert property (
    enable_in && write_in && !waitrequest_out && address_in == drive_ramp_pkg::A_MODE
    |=> st.mode == 8'($past(writedata_in)))
    else $error("mode write did not land");
  chk_max_write: assert property (
    enable_in && write_in && !waitrequest_out && address_in == drive_ramp_pkg::A_VMAX
    |=> st.vmax == $past(writedata_in))
    else $error("maximum write did not land");
  chk_read_hold: assert property (
    enable_in && !(req && waitrequest_out)
    |=> $stable(readdata_out))
    else $error("read data changed outside an access");
  chk_wait_idle: assert property (
    enable_in && !req
    |=> waitrequest_out)
    else $error("waitrequest dropped with no request");
  chk_enable_freeze: assert property (
    !enable_in
    |=> $stable(st))
    else $error("state moved while the enable was low");

  cov_reached: cover property (is_pv && $rose(st.reached));
  cov_halt_brake: cover property (is_vl && $rose(halt) && st.demand != 32'sh0);
  cov_clamp: cover property (is_vl && over_max && op_enabled_in);
  cov_jerk: cover property (is_pv && st.prof == drive_ramp_pkg::PROF_JERK && step < step_lim);
  cov_qstop: cover property (!st.ctrl[drive_ramp_pkg::QSTOP_BIT] && st.demand != 32'sh0);
endmodule : drive_velocity_ramp

// ### testbench/fieldbus_master_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fieldbus_master_model (
  // Clock.
  input  wire logic        clock_in,
  // Avalon-MM master side.
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  output logic [7:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [31:0]      writedata_out,
  // Raised when the slave never answers.
  output logic             hang_out
);
  initial
  begin
    address_out   = 8'h00;
    read_out      = 1'b0;
    write_out     = 1'b0;
    writedata_out = 32'h0000_0000;
    hang_out      = 1'b0;
  end

  // The request is held until waitrequest is seen low or 100 cycles pass, which raises hang_out; then the request is dropped.
  task automatic access(input logic [7:0] addr, input logic wr, input logic [31:0] data);
    int n;
    @(posedge clock_in);
    address_out   <= addr;
    read_out      <= ~wr;
    write_out     <= wr;
    writedata_out <= data;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (waitrequest_in !== 1'b0 && n < 100);
    if (n >= 100)
      hang_out <= 1'b1;
    read_out      <= 1'b0;
    write_out     <= 1'b0;
    // Stale data is scrambled so nothing can lean on a released value.
    writedata_out <= ~data;
  endtask : access
endmodule : fieldbus_master_model

// ### testbench/test_drive_velocity_mode_ramp.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_drive_velocity_mode_ramp;
  logic               clock_in = 1'b0;
  logic               reset_in = 1'b1;
  logic               enable_in = 1'b1;
  logic               op_enabled_in = 1'b1;
  logic signed [31:0] actual_rpm_in = 32'sh0000_7FFF;
  logic [7:0]         address;
  logic               rd_en;
  logic               wr_en;
  logic [31:0]        wdata;
  logic [31:0]        readdata_out;
  logic               waitrequest_out;
  logic signed [31:0] setpoint_out;
  logic [15:0]        status_out;
  logic               hang;
  logic [31:0]        rd_q[$];
  int                 miscompares = 0;
  int                 total_checks = 0;
  logic signed [31:0] prev_sp = 32'sh0;
  logic               prev_op = 1'b0;
  logic [15:0]        lfsr = 16'h4DA4;
  logic [7:0]         rst_addr [8] = '{drive_ramp_pkg::A_MODE, drive_ramp_pkg::A_CTRL,
    drive_ramp_pkg::A_VMAX, drive_ramp_pkg::A_DIMNUM, drive_ramp_pkg::A_DIMDEN,
    drive_ramp_pkg::A_ACCDT, drive_ramp_pkg::A_STAT, 8'hFC};
  logic [31:0]        rst_val [8] = '{32'h0, 32'h0104, 32'h7FFF_FFFF, 32'h1, 32'h1, 32'h1,
    32'h0, 32'h0};

  always #2.5 clock_in = ~clock_in;

  drive_velocity_ramp #(.TICK_CYCLES(4)) u_dut (
    .clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
    .address_in(address), .read_in(rd_en), .write_in(wr_en), .writedata_in(wdata),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .op_enabled_in(op_enabled_in), .actual_rpm_in(actual_rpm_in),
    .setpoint_out(setpoint_out), .status_out(status_out));

  fieldbus_master_model u_master (
    .clock_in(clock_in), .waitrequest_in(waitrequest_out), .readdata_in(readdata_out),
    .address_out(address), .read_out(rd_en), .write_out(wr_en),
    .writedata_out(wdata), .hang_out(hang));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", name, e, s);
      miscompares++;
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_master.access(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    u_master.access(a, 1'b0, 32'h0);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle

  task automatic wait_sp(input logic signed [31:0] e);
    int n;
    n = 0;
    while (setpoint_out !== e && n < 300)
    begin
      @(posedge clock_in);
      n++;
    end
    check("setpoint", e, setpoint_out);
    if (setpoint_out !== e)
      final_report();
  endtask : wait_sp

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  ////////////////////////////////////////////////////////////////////////////////
  // Read data is judged at the one edge where the slave completes the access.
  always @(posedge clock_in)
    if (rd_en && waitrequest_out === 1'b0)
      check("readdata", (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD_BEEF, readdata_out);

  // No ramp may move faster than five units a tick in any scenario here.
  always @(posedge clock_in)
  begin
    if (op_enabled_in && prev_op && !reset_in)
      if (setpoint_out - prev_sp > 5 || prev_sp - setpoint_out > 5)
        check("ramp_step", prev_sp + 5, setpoint_out);
    prev_sp <= setpoint_out;
    prev_op <= op_enabled_in;
  end

  always @(posedge hang)
  begin
    miscompares++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] t;
    logic [31:0] e;
    idle(6);
    reset_in <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(rst_addr[i], rst_val[i]);
    wr(drive_ramp_pkg::A_STAT, 32'hFFFF);
    rd(drive_ramp_pkg::A_STAT, 32'h0);
    wr(drive_ramp_pkg::A_ACCDS, 32'd5000);
    wr(drive_ramp_pkg::A_DECDS, 32'd5000);
    wr(drive_ramp_pkg::A_QSDS, 32'd2000);
    wr(drive_ramp_pkg::A_VMAX, 32'd12);
    wr(drive_ramp_pkg::A_VMIN, 32'd3);
    wr(drive_ramp_pkg::A_PROF, {24'h0, drive_ramp_pkg::PROF_JERK});
    wr(drive_ramp_pkg::A_MODE, {24'h0, drive_ramp_pkg::MODE_VL});
    wr(drive_ramp_pkg::A_CTRL, 32'h0004);
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      t = {27'h0, lfsr[4:0]};
      e = (t < 3) ? 32'd3 : ((t > 12) ? 32'd12 : t);
      wr(drive_ramp_pkg::A_VLTGT, t);
      wait_sp(e);
      rd(drive_ramp_pkg::A_STAT, (t < 3 || t > 12) ? 32'h0800 : 32'h0);
    end
    wr(drive_ramp_pkg::A_CTRL, 32'h0000);
    wait_sp(0);
    wr(drive_ramp_pkg::A_CTRL, 32'h0004);
    wait_sp(e);
    wr(drive_ramp_pkg::A_CTRL, 32'h0104);
    wait_sp(0);
    // Profile mode: the window dwell counts three ticks and reached sets on the fourth, waited out with margin.
    wr(drive_ramp_pkg::A_PVACC, 32'd5000);
    wr(drive_ramp_pkg::A_PVDEC, 32'd5000);
    wr(drive_ramp_pkg::A_PVQS, 32'd5000);
    wr(drive_ramp_pkg::A_WIN, 32'd2);
    wr(drive_ramp_pkg::A_WINT, 32'd3);
    wr(drive_ramp_pkg::A_PVTGT, 32'd7);
    wr(drive_ramp_pkg::A_MODE, {24'h0, drive_ramp_pkg::MODE_PV});
    wr(drive_ramp_pkg::A_CTRL, 32'h0004);
    actual_rpm_in <= 32'sd7;
    wait_sp(7);
    idle(40);
    rd(drive_ramp_pkg::A_STAT, 32'h0400);
    rd(drive_ramp_pkg::A_DEMAND, 32'd7);
    rd(drive_ramp_pkg::A_ACTUAL, 32'd7);
    actual_rpm_in <= 32'sd20;
    // The measured speed is registered first, so the flag drops one cycle later.
    idle(1);
    rd(drive_ramp_pkg::A_STAT, 32'h0);
    wr(drive_ramp_pkg::A_POL, 32'h40);
    actual_rpm_in <= -32'sd7;
    wait_sp(-7);
    idle(40);
    rd(drive_ramp_pkg::A_STAT, 32'h0400);
    op_enabled_in <= 1'b0;
    idle(3);
    check("setpoint", 32'h0, setpoint_out);
    op_enabled_in <= 1'b1;
    wait_sp(-7);
    actual_rpm_in <= 32'sd0;
    wr(drive_ramp_pkg::A_CTRL, 32'h0104);
    wait_sp(0);
    idle(40);
    rd(drive_ramp_pkg::A_STAT, 32'h0400);
    wr(drive_ramp_pkg::A_CTRL, 32'h0004);
    enable_in <= 1'b0;
    idle(12);
    check("frozen_setpoint", 32'h0, setpoint_out);
    enable_in <= 1'b1;
    wait_sp(-7);
    wr(drive_ramp_pkg::A_MODE, 32'h0);
    wait_sp(0);
    idle(4);
    final_report();
  end
endmodule : test_drive_velocity_mode_ramp
